// >>> logic/hsbuf_consts.svh
// Timing counts, line indices and field widths for the hot-swap bus buffer control
`ifndef HSBUF_CONSTS_SVH
`define HSBUF_CONSTS_SVH

// Clock
`define HSBUF_CLK_HZ 20000000
`define HSBUF_CLK_PERIOD_NS 50

// Line index within each two-line bus vector
`define HSBUF_DATA 0
`define HSBUF_CLOCK 1

// Bus idle qualifier, typical figure, least time rounds up
`define HSBUF_T_IDLE_NS 95000
`define HSBUF_IDLE_CYC ((`HSBUF_T_IDLE_NS + `HSBUF_CLK_PERIOD_NS - 1) / `HSBUF_CLK_PERIOD_NS)
`define HSBUF_IDLE_W 11

// Longest STOP to ready delay, rounds down
`define HSBUF_T_STOP_MAX_NS 2000
`define HSBUF_STOP_CYC (`HSBUF_T_STOP_MAX_NS / `HSBUF_CLK_PERIOD_NS)

// Longest enable fall to ready low delay, rounds down
`define HSBUF_T_DISABLE_MAX_NS 200
`define HSBUF_DISABLE_CYC (`HSBUF_T_DISABLE_MAX_NS / `HSBUF_CLK_PERIOD_NS)

// Stuck bus timer
`define HSBUF_T_STUCK_MS 40
`define HSBUF_STUCK_CYC ((`HSBUF_T_STUCK_MS * 1000000) / `HSBUF_CLK_PERIOD_NS)
`define HSBUF_STUCK_W 20

// Recovery clock, typical frequency, half period in cycles
`define HSBUF_REC_FREQ_HZ 8500
`define HSBUF_REC_HALF_CYC (`HSBUF_CLK_HZ / (2 * `HSBUF_REC_FREQ_HZ))
`define HSBUF_REC_HALF_W 11
`define HSBUF_REC_PULSES 16
`define HSBUF_REC_PULSE_W 5

// Cycles a side is ignored after its own low drive is released
`define HSBUF_HOLDOFF_CYC 3'h4
`define HSBUF_HOLDOFF_W 3

`endif

// >>> logic/hsbuf_ctrl.sv
// Connection, pass-through and stuck bus recovery control of the hot-swap bus buffer
// Notes on behaviour
// - Stay isolated until backplane idle or STOP
// - Card lines high plus idle or STOP
// - Idle qualifier: backplane high about 95 us
// - Ready within 2 us after STOP
// - Enable fall pulls ready low within 200 ns
// - Enable low: pins released, ready low
// - Supply lockout ignores all bus activity
// - Enable high starts detection, enters idle
// - Precharge in idle, off when connected
// - Connected: lows pass both ways, both lines
// - Stretching and arbitration pass without lockup
// - Stay joined until enable low, supply lockout or stuck
// - Card line low 40 ms means stuck
// - Stuck bus disconnects despite enable high
// - Recovery first disconnects and drops ready
// - Pulse card clock until data free, max 16
// - Then STOP on card side, release lines
// - After recovery requalify from idle state
// - Ready open drain, low while disconnected
// - Recovery clock between 5.5 and 14 kHz
`include "hsbuf_consts.svh"
`default_nettype none
module hsbuf_ctrl
   import hsbuf_pkg::*;
#(
   parameter int STUCK_CYC = `HSBUF_STUCK_CYC
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic supply_ok_i,
   input wire logic en_i,
   input wire logic backplane_data_line_i,
   output logic backplane_data_line_o,
   output logic backplane_data_line_oe_n_o,
   input wire logic backplane_clock_line_i,
   output logic backplane_clock_line_o,
   output logic backplane_clock_line_oe_n_o,
   input wire logic card_data_line_i,
   output logic card_data_line_o,
   output logic card_data_line_oe_n_o,
   input wire logic card_clock_line_i,
   output logic card_clock_line_o,
   output logic card_clock_line_oe_n_o,
   output logic ready_o,
   output logic ready_oe_n_o,
   output logic precharge_o
);
   localparam int STOP_MAX = `HSBUF_STOP_CYC;
   localparam int DIS_MAX = `HSBUF_DISABLE_CYC;

   // Synchronised inputs
   logic [5:0] raw_in;
   logic [5:0] syn_in;
   logic [1:0] bp_s;
   logic [1:0] cd_s;
   logic en_s;
   logic ok_s;
   logic stop_pulse;

   assign raw_in = {supply_ok_i, en_i, card_clock_line_i, card_data_line_i,
                    backplane_clock_line_i, backplane_data_line_i};

   hsbuf_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .raw_i(raw_in),
      .sync_o(syn_in)
   );

   assign bp_s = syn_in[1:0];
   assign cd_s = syn_in[3:2];
   assign en_s = syn_in[4];
   assign ok_s = syn_in[5];

   hsbuf_stop_det u_stop (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .data_i(bp_s[`HSBUF_DATA]),
      .clock_i(bp_s[`HSBUF_CLOCK]),
      .stop_o(stop_pulse)
   );

   // State and counters
   hsbuf_state_t state_r;
   hsbuf_state_t state_nxt;
   logic [`HSBUF_IDLE_W-1:0] idle_cnt_r;
   logic [`HSBUF_IDLE_W-1:0] idle_cnt_nxt;
   logic stop_seen_r;
   logic stop_seen_nxt;
   logic [`HSBUF_STUCK_W-1:0] stuck_cnt_r;
   logic [`HSBUF_STUCK_W-1:0] stuck_cnt_nxt;
   logic [`HSBUF_REC_HALF_W-1:0] half_cnt_r;
   logic [`HSBUF_REC_HALF_W-1:0] half_cnt_nxt;
   logic phase_r;
   logic phase_nxt;
   logic [`HSBUF_REC_PULSE_W-1:0] pulse_cnt_r;
   logic [`HSBUF_REC_PULSE_W-1:0] pulse_cnt_nxt;
   logic [1:0] step_r;
   logic [1:0] step_nxt;
   logic [1:0] drv_cd_r;
   logic [1:0] drv_cd_nxt;
   logic [1:0] drv_bp_r;
   logic [1:0] drv_bp_nxt;
   logic [1:0][`HSBUF_HOLDOFF_W-1:0] cd_blank_r;
   logic [1:0][`HSBUF_HOLDOFF_W-1:0] cd_blank_nxt;
   logic [1:0][`HSBUF_HOLDOFF_W-1:0] bp_blank_r;
   logic [1:0][`HSBUF_HOLDOFF_W-1:0] bp_blank_nxt;
   logic ready_rel_r;
   logic ready_rel_nxt;
   logic precharge_r;
   logic precharge_nxt;

   // Qualifiers and decodes
   logic bp_high;
   logic cd_high;
   logic idle_met;
   logic connect_ok;
   logic stuck;
   logic half_done;
   logic last_pulse;
   logic in_rec;
   logic rec_clk_stay;
   logic rec_stop_stay;
   logic pass_en;
   logic [1:0] take_cd;
   logic [1:0] take_bp;
   logic [1:0] rec_cd;

   assign bp_high = bp_s == 2'h3;
   assign cd_high = cd_s == 2'h3;
   assign idle_met = idle_cnt_r == `HSBUF_IDLE_W'(`HSBUF_IDLE_CYC);
   assign connect_ok = cd_high & (idle_met | stop_seen_r);
   assign stuck = (stuck_cnt_r == `HSBUF_STUCK_W'(STUCK_CYC - 1)) & ~cd_high;
   assign half_done = half_cnt_r == `HSBUF_REC_HALF_W'(`HSBUF_REC_HALF_CYC - 1);
   assign last_pulse = pulse_cnt_r == `HSBUF_REC_PULSE_W'(`HSBUF_REC_PULSES - 1);
   assign in_rec = (state_r == ST_REC_CLK) | (state_r == ST_REC_STOP);
   assign rec_clk_stay = (state_r == ST_REC_CLK) & (state_nxt == ST_REC_CLK);
   assign rec_stop_stay = (state_r == ST_REC_STOP) & (state_nxt == ST_REC_STOP);
   assign pass_en = (state_r == ST_ACTIVE) & (state_nxt == ST_ACTIVE);

   // Main sequence
   always_comb begin
      state_nxt = state_r;
      if (!ok_s) begin
         state_nxt = ST_LOCKOUT;
      end else if (!en_s) begin
         state_nxt = ST_OFF;
      end else begin
         case (state_r)
            ST_LOCKOUT, ST_OFF: begin
               state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
               if (connect_ok) begin
                  state_nxt = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (stuck) begin
                  state_nxt = ST_REC_CLK;
               end else begin
                  state_nxt = ST_ACTIVE;
               end
            end
            ST_REC_CLK: begin
               if (half_done && phase_r && (cd_s[`HSBUF_DATA] || last_pulse)) begin
                  state_nxt = ST_REC_STOP;
               end
            end
            ST_REC_STOP: begin
               if (half_done && step_r == 2'h3) begin
                  state_nxt = ST_IDLE;
               end
            end
            default: begin
               state_nxt = ST_LOCKOUT;
            end
         endcase
      end
   end

   // Idle timer restarts on any backplane low
   assign idle_cnt_nxt = (state_r != ST_IDLE || !bp_high) ? '0 :
                         (idle_met ? idle_cnt_r : idle_cnt_r + `HSBUF_IDLE_W'(1));
   // A STOP counts until the backplane goes low again
   assign stop_seen_nxt = (state_r == ST_IDLE) & (stop_pulse | (stop_seen_r & bp_high));

   assign stuck_cnt_nxt = (state_r != ST_ACTIVE || cd_high) ? '0 :
                          (stuck ? stuck_cnt_r : stuck_cnt_r + `HSBUF_STUCK_W'(1));

   // Recovery timing
   assign half_cnt_nxt = (in_rec && !half_done && state_nxt == state_r) ?
                         half_cnt_r + `HSBUF_REC_HALF_W'(1) : '0;
   assign phase_nxt = rec_clk_stay & (phase_r ^ half_done);
   assign pulse_cnt_nxt = rec_clk_stay ?
                          pulse_cnt_r + `HSBUF_REC_PULSE_W'(half_done & phase_r) : '0;
   assign step_nxt = rec_stop_stay ? step_r + 2'(half_done) : 2'h0;

   // Clock low on first half of each pulse; STOP is clock low, data low, clock up, data up
   assign rec_cd[`HSBUF_CLOCK] = ((state_nxt == ST_REC_CLK) & ~phase_nxt) |
                                 ((state_nxt == ST_REC_STOP) & (step_nxt < 2'h2));
   assign rec_cd[`HSBUF_DATA] = (state_nxt == ST_REC_STOP) &
                                ((step_nxt == 2'h1) | (step_nxt == 2'h2));

   // Pass-through per line
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         // A side we drive low reads back our own low, so it is ignored while driven and
         // for a short hold-off after release; backplane wins a tie
         assign take_cd[gi] = pass_en & ~bp_s[gi] & ~drv_bp_r[gi] & (bp_blank_r[gi] == '0);
         assign take_bp[gi] = pass_en & ~cd_s[gi] & ~drv_cd_r[gi] & (cd_blank_r[gi] == '0) &
                              ~take_cd[gi];
         assign drv_cd_nxt[gi] = take_cd[gi] | rec_cd[gi];
         assign drv_bp_nxt[gi] = take_bp[gi];
         assign cd_blank_nxt[gi] = (drv_cd_r[gi] & ~drv_cd_nxt[gi]) ? `HSBUF_HOLDOFF_CYC :
                                   ((cd_blank_r[gi] != '0) ? cd_blank_r[gi] - 3'h1 : 3'h0);
         assign bp_blank_nxt[gi] = (drv_bp_r[gi] & ~drv_bp_nxt[gi]) ? `HSBUF_HOLDOFF_CYC :
                                   ((bp_blank_r[gi] != '0) ? bp_blank_r[gi] - 3'h1 : 3'h0);
      end
   endgenerate

   assign ready_rel_nxt = state_nxt == ST_ACTIVE;
   assign precharge_nxt = state_nxt == ST_IDLE;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_LOCKOUT;
         idle_cnt_r <= '0;
         stop_seen_r <= 1'b0;
         stuck_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         idle_cnt_r <= idle_cnt_nxt;
         stop_seen_r <= stop_seen_nxt;
         stuck_cnt_r <= stuck_cnt_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         half_cnt_r <= '0;
         phase_r <= 1'b0;
         pulse_cnt_r <= '0;
         step_r <= 2'h0;
      end else begin
         half_cnt_r <= half_cnt_nxt;
         phase_r <= phase_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         step_r <= step_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         drv_cd_r <= 2'h0;
         drv_bp_r <= 2'h0;
         cd_blank_r <= '0;
         bp_blank_r <= '0;
         ready_rel_r <= 1'b0;
         precharge_r <= 1'b0;
      end else begin
         drv_cd_r <= drv_cd_nxt;
         drv_bp_r <= drv_bp_nxt;
         cd_blank_r <= cd_blank_nxt;
         bp_blank_r <= bp_blank_nxt;
         ready_rel_r <= ready_rel_nxt;
         precharge_r <= precharge_nxt;
      end
   end

   // Open-drain pins only ever pull low
   assign backplane_data_line_o = 1'b0;
   assign backplane_clock_line_o = 1'b0;
   assign card_data_line_o = 1'b0;
   assign card_clock_line_o = 1'b0;
   assign ready_o = 1'b0;
   assign backplane_data_line_oe_n_o = ~drv_bp_r[`HSBUF_DATA];
   assign backplane_clock_line_oe_n_o = ~drv_bp_r[`HSBUF_CLOCK];
   assign card_data_line_oe_n_o = ~drv_cd_r[`HSBUF_DATA];
   assign card_clock_line_oe_n_o = ~drv_cd_r[`HSBUF_CLOCK];
   assign ready_oe_n_o = ready_rel_r;
   assign precharge_o = precharge_r;

   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_isolated;
      ready_oe_n_o |-> state_r == ST_ACTIVE && !precharge_o;
   endproperty
   a_isolated: assert property (p_isolated) else $error("ready released while not connected");

   property p_qualified;
      $rose(ready_oe_n_o) |-> $past(cd_s) == 2'h3 && ($past(idle_met) || $past(stop_seen_r));
   endproperty
   a_qualified: assert property (p_qualified) else $error("connected without qualifier");

   property p_idle_connect;
      state_r == ST_IDLE && idle_met && cd_high && en_s && ok_s |=> ready_oe_n_o;
   endproperty
   a_idle_connect: assert property (p_idle_connect) else $error("idle qualifier did not connect");

   property p_stop_ready;
      state_r == ST_IDLE && stop_pulse && cd_high && en_s && ok_s
         ##1 (cd_high && en_s && ok_s) |-> ##[0:STOP_MAX] ready_oe_n_o;
   endproperty
   a_stop_ready: assert property (p_stop_ready) else $error("ready late after STOP");

   property p_disable;
      $fell(en_s) |-> ##[0:DIS_MAX] !ready_oe_n_o;
   endproperty
   a_disable: assert property (p_disable) else $error("ready not low after enable fall");

   property p_off_iso;
      !en_s ##1 !en_s |-> !ready_oe_n_o && drv_cd_r == 2'h0 && drv_bp_r == 2'h0 && !precharge_o;
   endproperty
   a_off_iso: assert property (p_off_iso) else $error("pins driven while disabled");

   property p_lockout;
      !ok_s |=> state_r == ST_LOCKOUT && drv_cd_r == 2'h0 && drv_bp_r == 2'h0;
   endproperty
   a_lockout: assert property (p_lockout) else $error("activity during supply lockout");

   property p_pass;
      take_cd[`HSBUF_CLOCK] |=> !card_clock_line_oe_n_o && backplane_clock_line_oe_n_o;
   endproperty
   a_pass: assert property (p_pass) else $error("backplane clock low not passed to card");

   property p_no_both;
      !(drv_cd_r[`HSBUF_DATA] && drv_bp_r[`HSBUF_DATA]);
   endproperty
   a_no_both: assert property (p_no_both) else $error("data driven low on both sides");

   property p_stuck;
      state_r == ST_ACTIVE && stuck && en_s && ok_s |=> state_r == ST_REC_CLK && !ready_oe_n_o
         && backplane_data_line_oe_n_o && backplane_clock_line_oe_n_o;
   endproperty
   a_stuck: assert property (p_stuck) else $error("stuck bus did not disconnect");

   property p_pulses;
      state_r == ST_REC_CLK |-> pulse_cnt_r < `HSBUF_REC_PULSE_W'(`HSBUF_REC_PULSES);
   endproperty
   a_pulses: assert property (p_pulses) else $error("more than sixteen recovery pulses");

   property p_stop_seq;
      state_r == ST_REC_STOP && step_r == 2'h2 |-> card_clock_line_oe_n_o && !card_data_line_oe_n_o;
   endproperty
   a_stop_seq: assert property (p_stop_seq) else $error("recovery STOP order wrong");

   property p_rec_half;
      $fell(card_clock_line_oe_n_o) && state_r == ST_REC_CLK |-> !card_clock_line_oe_n_o [*8];
   endproperty
   a_rec_half: assert property (p_rec_half) else $error("recovery clock low phase too short");
endmodule
`default_nettype wire

// >>> logic/hsbuf_pkg.sv
// Types shared by the hot-swap bus buffer control
`default_nettype none
package hsbuf_pkg;
   typedef enum logic [2:0] {
      ST_LOCKOUT,
      ST_OFF,
      ST_IDLE,
      ST_ACTIVE,
      ST_REC_CLK,
      ST_REC_STOP
   } hsbuf_state_t;
endpackage
`default_nettype wire

// >>> logic/hsbuf_stop_det.sv
// STOP condition detector on synchronised backplane lines
`default_nettype none
module hsbuf_stop_det (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic data_i,
   input wire logic clock_i,
   output logic stop_o
);
   logic data_prev_r;
   logic clock_prev_r;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data_prev_r <= 1'b1;
         clock_prev_r <= 1'b1;
      end else begin
         data_prev_r <= data_i;
         clock_prev_r <= clock_i;
      end
   end

   // Data rises while clock stays high
   assign stop_o = data_i & ~data_prev_r & clock_i & clock_prev_r;
endmodule
`default_nettype wire

// >>> logic/hsbuf_sync.sv
// Two-flop synchronisers for the pin inputs of the buffer control
`default_nettype none
module hsbuf_sync (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [5:0] raw_i,
   output logic [5:0] sync_o
);
   logic [5:0] meta_r;
   logic [5:0] sync_r;

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_bit
         // Bus lines reset to their released level, enable and supply to off
         localparam logic RST_V = (gi < 4) ? 1'b1 : 1'b0;
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               meta_r[gi] <= RST_V;
               sync_r[gi] <= RST_V;
            end else begin
               meta_r[gi] <= raw_i[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   assign sync_o = sync_r;
endmodule
`default_nettype wire

// >>> sim/hsbuf_ctrl_tb.sv
// Self-checking bench of the hot-swap bus buffer control
`default_nettype none
module hsbuf_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STUCK = 2000;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic supply_ok_i = 1'b0;
   logic en_i = 1'b0;
   logic bp_data_low = 1'b0;
   logic bp_clock_low = 1'b0;
   logic card_data_low = 1'b0;
   logic card_clock_low = 1'b0;
   logic stuck = 1'b0;
   logic [4:0] stuck_falls = 5'h00;
   logic bp_data, bp_clock, card_data, card_clock, ready;
   logic bp_data_oe_n, bp_clock_oe_n, card_data_oe_n, card_clock_oe_n, ready_oe_n, precharge;
   logic [4:0] od_val;
   logic mon_clr = 1'b0;
   logic pc_prev = 1'b1;
   logic pd_prev = 1'b1;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int rises = 0;
   int stops = 0;
   int rise_t1 = 0;
   int rise_t2 = 0;

   always #25 ref_clk_i = ~ref_clk_i;

   hsbuf_ctrl #(.STUCK_CYC(STUCK)) dut (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i), .en_i(en_i),
      .backplane_data_line_i(bp_data), .backplane_data_line_o(od_val[0]),
      .backplane_data_line_oe_n_o(bp_data_oe_n),
      .backplane_clock_line_i(bp_clock), .backplane_clock_line_o(od_val[1]),
      .backplane_clock_line_oe_n_o(bp_clock_oe_n),
      .card_data_line_i(card_data), .card_data_line_o(od_val[2]), .card_data_line_oe_n_o(card_data_oe_n),
      .card_clock_line_i(card_clock), .card_clock_line_o(od_val[3]), .card_clock_line_oe_n_o(card_clock_oe_n),
      .ready_o(od_val[4]), .ready_oe_n_o(ready_oe_n), .precharge_o(precharge)
   );

   hsbuf_far far (
      .bp_data_oe_n_i(bp_data_oe_n), .bp_clock_oe_n_i(bp_clock_oe_n), .card_data_oe_n_i(card_data_oe_n),
      .card_clock_oe_n_i(card_clock_oe_n), .ready_oe_n_i(ready_oe_n), .bp_data_low_i(bp_data_low),
      .bp_clock_low_i(bp_clock_low), .card_data_low_i(card_data_low), .card_clock_low_i(card_clock_low),
      .stuck_i(stuck), .stuck_falls_i(stuck_falls), .bp_data_o(bp_data), .bp_clock_o(bp_clock),
      .card_data_o(card_data), .card_clock_o(card_clock), .ready_o(ready)
   );

   // Card bus monitor: clock rises and STOP conditions
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      pc_prev <= card_clock;
      pd_prev <= card_data;
      if (mon_clr) begin
         rises <= 0;
         stops <= 0;
      end else begin
         if (card_clock === 1'b1 && pc_prev === 1'b0) begin
            rises <= rises + 1;
            if (rises == 0) rise_t1 <= cyc;
            if (rises == 1) rise_t2 <= cyc;
         end
         if (card_data === 1'b1 && pd_prev === 1'b0 && card_clock === 1'b1 && pc_prev === 1'b1) begin
            stops <= stops + 1;
         end
      end
   end

   task automatic chk(input bit ok, input string msg);
      checks++;
      if (!ok) begin
         fail_count++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wait_rdy(input logic v, input int lim, output int n);
      n = 0;
      #1;
      while (ready_oe_n !== v && n < lim) begin
         look(1);
         n++;
      end
   endtask

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic t_lockout;
      int n;
      tick(1);
      en_i <= 1'b1;
      bp_data_low <= 1'b1;
      tick(50);
      bp_data_low <= 1'b0;
      wait_rdy(1'b1, 2500, n);
      chk(ready_oe_n === 1'b0 && precharge === 1'b0, "left lockout");
      chk({bp_data_oe_n, bp_clock_oe_n, card_data_oe_n, card_clock_oe_n} === 4'hf, "line driven");
      chk(od_val === 5'h00, "open drain value not low");
   endtask

   task automatic t_stop_join;
      int n;
      tick(1);
      bp_data_low <= 1'b1;
      supply_ok_i <= 1'b1;
      look(10);
      chk(precharge === 1'b1 && ready_oe_n === 1'b0, "no idle state");
      look(200);
      chk(ready_oe_n === 1'b0, "joined while backplane busy");
      tick(1);
      bp_data_low <= 1'b0;
      wait_rdy(1'b1, 45, n);
      chk(n <= 40 && ready_oe_n === 1'b1, "no join after STOP");
      chk(ready === 1'b1, "ready not released");
      chk(precharge === 1'b0, "precharge still on");
   endtask

   task automatic t_pass;
      // Backplane traffic only while ready is released
      chk(ready === 1'b1, "traffic started while ready low");
      tick(1);
      for (int i = 0; i < 8; i++) begin
         bp_clock_low <= ~bp_clock_low;
         look(3);
         chk(card_clock === ~bp_clock_low, "card clock does not follow");
         tick(1);
      end
      card_data_low <= 1'b1;
      look(4);
      chk(bp_data === 1'b0, "card low not passed");
      tick(1);
      card_data_low <= 1'b0;
      bp_clock_low <= 1'b1;
      tick(6);
      card_clock_low <= 1'b1;
      tick(6);
      bp_clock_low <= 1'b0;
      look(12);
      chk(bp_data === 1'b1 && bp_clock === 1'b0, "stretch lost");
      tick(1);
      card_clock_low <= 1'b0;
      look(12);
      chk(bp_clock === 1'b1 && card_clock === 1'b1, "bus locked low");
      chk(ready_oe_n === 1'b1, "link dropped");
   endtask

   task automatic t_disable;
      int n;
      tick(1);
      bp_clock_low <= 1'b1;
      tick(5);
      en_i <= 1'b0;
      wait_rdy(1'b0, 6, n);
      chk(n <= 4, "ready slow to drop");
      look(4);
      chk({bp_data_oe_n, bp_clock_oe_n, card_data_oe_n, card_clock_oe_n} === 4'hf && ready === 1'b0,
          "not isolated");
      tick(1);
      bp_clock_low <= 1'b0;
      card_data_low <= 1'b1;
      en_i <= 1'b1;
      wait_rdy(1'b1, 2500, n);
      chk(ready_oe_n === 1'b0, "joined with card line low");
      tick(1);
      card_data_low <= 1'b0;
      wait_rdy(1'b1, 3000, n);
      chk(ready_oe_n === 1'b1, "no join after card release");
      tick(1);
      en_i <= 1'b0;
      tick(10);
      en_i <= 1'b1;
      wait_rdy(1'b1, 3100, n);
      chk(n >= 1890 && n <= 3000, "idle qualifier time");
   endtask

   task automatic t_stuck(input logic [4:0] falls, input int exp_rises, input int exp_stops, input int lim);
      int n;
      tick(1);
      stuck_falls <= falls;
      stuck <= 1'b1;
      wait_rdy(1'b0, STUCK + 20, n);
      chk(n >= STUCK && n <= STUCK + 10, "stuck timer length");
      mon_clr <= 1'b1;
      look(2);
      mon_clr <= 1'b0;
      chk(bp_data === 1'b1 && ready === 1'b0, "still joined");
      n = 0;
      while (precharge !== 1'b1 && n < lim) begin
         look(1);
         n++;
      end
      chk(rises == exp_rises, "recovery pulse count");
      chk(stops == exp_stops, "recovery STOP");
      chk(rise_t2 - rise_t1 >= 1428 && rise_t2 - rise_t1 <= 3636, "recovery clock rate");
      chk(card_clock === 1'b1 && card_data_oe_n === 1'b1 && ready_oe_n === 1'b0, "lines held");
      wait_rdy(1'b1, 2500, n);
      chk(ready_oe_n === (exp_stops == 1 ? 1'b1 : 1'b0) && n >= 1890, "requalify");
   endtask

   initial begin
      tick(12);
      arst_n_i <= 1'b1;
      t_lockout();
      t_stop_join();
      t_pass();
      t_disable();
      t_stuck(5'h05, 6, 1, 19500);
      t_stuck(5'h00, 17, 0, 43000);
      test_done();
   end

   initial begin
      #4500000;
      fail_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
`default_nettype wire

// >>> sim/hsbuf_far.sv
// Far side model: backplane controller, card targets and bus pull-ups
`default_nettype none
module hsbuf_far (
   input wire logic bp_data_oe_n_i,
   input wire logic bp_clock_oe_n_i,
   input wire logic card_data_oe_n_i,
   input wire logic card_clock_oe_n_i,
   input wire logic ready_oe_n_i,
   input wire logic bp_data_low_i,
   input wire logic bp_clock_low_i,
   input wire logic card_data_low_i,
   input wire logic card_clock_low_i,
   input wire logic stuck_i,
   input wire logic [4:0] stuck_falls_i,
   output logic bp_data_o,
   output logic bp_clock_o,
   output logic card_data_o,
   output logic card_clock_o,
   output logic ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] falls_r = 5'h00;
   logic stuck_hold;
   // Every line has a pull-up, so a released line reads high
   assign bp_data_o = bp_data_oe_n_i & ~bp_data_low_i;
   assign bp_clock_o = bp_clock_oe_n_i & ~bp_clock_low_i;
   assign card_data_o = card_data_oe_n_i & ~card_data_low_i & ~stuck_hold;
   assign card_clock_o = card_clock_oe_n_i & ~card_clock_low_i;
   assign ready_o = ready_oe_n_i;
   // Stuck target frees data after a set count of clock falls; zero never frees it
   assign stuck_hold = stuck_i & ((stuck_falls_i == 5'h00) | (falls_r < stuck_falls_i));
   always @(negedge card_clock_o or negedge stuck_i) begin
      if (!stuck_i) begin
         falls_r <= 5'h00;
      end else begin
         falls_r <= falls_r + 5'h01;
      end
   end
endmodule
`default_nettype wire
